// File: rtl/rtcirq_flags.sv
// Interrupt enable, flag and sync status registers of the counter.
// Assumes event pulses and sync busy are synchronous to mclk_in.
`timescale 1ns/1ns
module rtcirq_flags (
  input  wire logic       mclk_in,
  input  wire logic       reset_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  input  wire logic       counter_wrap_in,
  input  wire logic [1:0] match_chan_n_in,
  input  wire logic       calendar_alarm_in,
  input  wire logic       sync_busy_in,
  input  wire logic       sync_cause_in,
  output logic            irq_out
);

  logic [1:0] view;
  logic [7:0] irq_enable;
  logic [7:0] irq_flags;
  logic       sync_pending;
  logic       sync_quiet;
  logic [7:0] valid_mask;
  logic [7:0] next_enable;
  logic [7:0] next_flags;
  logic [7:0] event_set;
  logic [7:0] flag_clear;
  logic [7:0] next_rdata;
  logic       busy_fall;
  logic       wr_view;
  logic       wr_set;
  logic       wr_clr;
  logic       wr_flag;

  assign wr_view = wr_in && (addr_in == rtcirq_pkg::OFS_VIEW);
  assign wr_set  = wr_in && (addr_in == rtcirq_pkg::OFS_ENABLE_SET);
  assign wr_clr  = wr_in && (addr_in == rtcirq_pkg::OFS_ENABLE_CLEAR);
  assign wr_flag = wr_in && (addr_in == rtcirq_pkg::OFS_FLAGS);

  // Bits that exist in the selected view
  always_comb begin
    unique case (view)
      rtcirq_pkg::VIEW_COUNT16:  valid_mask = rtcirq_pkg::MASK_COUNT16;
      rtcirq_pkg::VIEW_CALENDAR: valid_mask = rtcirq_pkg::MASK_CALENDAR;
      default:                   valid_mask = rtcirq_pkg::MASK_COUNT32;
    endcase
  end

  // View select; code 3 is treated as the 32-bit view
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      view <= rtcirq_pkg::RESET_VIEW;
    end else if (wr_view) begin
      view <= wdata_in[1:0];
    end
  end

  // Enables: one-to-set and one-to-clear over a shared layout
  always_comb begin
    next_enable = irq_enable;
    if (wr_set) begin
      next_enable = irq_enable | (wdata_in & valid_mask);
    end else if (wr_clr) begin
      next_enable = irq_enable & ~(wdata_in & valid_mask);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      irq_enable <= rtcirq_pkg::RESET_ENABLE;
    end else begin
      irq_enable <= next_enable;
    end
  end

  // Sync busy tracking; quiet marks a busy spell started by enable or soft reset
  assign busy_fall = sync_pending && !sync_busy_in;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      sync_pending <= 1'b0;
    end else begin
      sync_pending <= sync_busy_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      sync_quiet <= 1'b0;
    end else if (sync_busy_in && !sync_pending) begin
      sync_quiet <= sync_cause_in;
    end else if (sync_busy_in && sync_cause_in) begin
      sync_quiet <= 1'b1;
    end
  end

  // Event sources per view; bit 0 is match zero or the alarm
  always_comb begin
    event_set = 8'h00;
    event_set[rtcirq_pkg::BIT_WRAP] = counter_wrap_in;
    event_set[rtcirq_pkg::BIT_SYNC_DONE] = busy_fall && !sync_quiet;
    if (view == rtcirq_pkg::VIEW_CALENDAR) begin
      event_set[rtcirq_pkg::BIT_CHAN_ZERO] = calendar_alarm_in;
    end else begin
      event_set[rtcirq_pkg::BIT_CHAN_ZERO] = match_chan_n_in[0];
    end
    if (view == rtcirq_pkg::VIEW_COUNT16) begin
      event_set[rtcirq_pkg::BIT_CHAN_ONE] = match_chan_n_in[1];
    end
  end

  assign flag_clear = wr_flag ? wdata_in : 8'h00;

  // Set wins over a clear in the same cycle so no event is lost
  always_comb begin
    next_flags = ((irq_flags & ~flag_clear) | event_set) & valid_mask;
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      irq_flags <= rtcirq_pkg::RESET_FLAGS;
    end else begin
      irq_flags <= next_flags;
    end
  end

  // Registered request: one cycle behind the flag, a deliberate glitch-free output
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_flags & irq_enable);
    end
  end

  // Read data stands for one cycle after the strobe, zero otherwise
  always_comb begin
    next_rdata = 8'h00;
    if (rd_in) begin
      unique case (addr_in)
        rtcirq_pkg::OFS_ENABLE_SET:   next_rdata = irq_enable;
        rtcirq_pkg::OFS_ENABLE_CLEAR: next_rdata = irq_enable;
        rtcirq_pkg::OFS_FLAGS:        next_rdata = irq_flags;
        rtcirq_pkg::OFS_STATUS:       next_rdata = {sync_pending, 7'h00};
        rtcirq_pkg::OFS_VIEW:         next_rdata = {6'h00, view};
        default:                      next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rdata_out <= rtcirq_pkg::RESET_STATUS;
    end else begin
      rdata_out <= next_rdata;
    end
  end

  default clocking cb @(posedge mclk_in);
  endclocking

  default disable iff (reset_in);

  sequence s_set_wrap;
    wr_set && wdata_in[7];
  endsequence

  sequence s_set_sync;
    wr_set && wdata_in[6];
  endsequence

  sequence s_clr_alarm;
    wr_clr && wdata_in[0] && view == rtcirq_pkg::VIEW_CALENDAR;
  endsequence

  sequence s_busy_spell;
    sync_busy_in && !sync_cause_in && !sync_pending ##1 (sync_busy_in && !sync_cause_in) [*2] ##1 !sync_busy_in;
  endsequence

  sequence s_quiet_spell;
    sync_busy_in && sync_cause_in && !sync_pending ##1 sync_busy_in [*2] ##1 !sync_busy_in;
  endsequence

  sequence s_loud_fall;
    busy_fall && !sync_quiet;
  endsequence

  property p_clr_alarm;
    s_clr_alarm |=> !irq_enable[0];
  endproperty
  a_clr_alarm: assert property (p_clr_alarm) else $error("alarm enable not cleared");

  property p_set_wrap;
    s_set_wrap |=> irq_enable[7] ##1 (irq_enable[7] || $past(wr_clr));
  endproperty
  a_set_wrap: assert property (p_set_wrap) else $error("wrap enable not set");

  property p_set_sync;
    s_set_sync |=> irq_enable[6];
  endproperty
  a_set_sync: assert property (p_set_sync) else $error("sync enable not set");

  property p_chan_one_32;
    wr_set && view == rtcirq_pkg::VIEW_COUNT32 |=> !irq_enable[1] || $past(irq_enable[1]);
  endproperty
  a_chan_one_32: assert property (p_chan_one_32) else $error("channel one enable in 32-bit view");

  property p_chan_one_16;
    wr_set && wdata_in[1:0] == 2'h3 && view == rtcirq_pkg::VIEW_COUNT16 |=> irq_enable[1:0] == 2'h3;
  endproperty
  a_chan_one_16: assert property (p_chan_one_16) else $error("16-bit view enables not set");

  property p_set_alarm;
    wr_set && wdata_in[0] && view == rtcirq_pkg::VIEW_CALENDAR |=> irq_enable[0];
  endproperty
  a_set_alarm: assert property (p_set_alarm) else $error("alarm enable not set");

  property p_irq;
    (|(irq_flags & irq_enable)) |=> irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("request missing");

  property p_irq_quiet;
    !(|(irq_flags & irq_enable)) |=> !irq_out;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("request without cause");

  property p_flag_clear;
    wr_flag && wdata_in[7] && !counter_wrap_in |=> !irq_flags[7];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("wrap flag not cleared");

  property p_wrap;
    counter_wrap_in |=> irq_flags[7];
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag not set");

  property p_match;
    match_chan_n_in[0] && view != rtcirq_pkg::VIEW_CALENDAR |=> irq_flags[0];
  endproperty
  a_match: assert property (p_match) else $error("match flag not set");

  property p_alarm;
    calendar_alarm_in && view == rtcirq_pkg::VIEW_CALENDAR |=> irq_flags[0];
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm flag not set");

  property p_sync_done;
    s_busy_spell |=> irq_flags[6];
  endproperty
  a_sync_done: assert property (p_sync_done) else $error("sync done not flagged");

  property p_status;
    rd_in && addr_in == rtcirq_pkg::OFS_STATUS |=> rdata_out == {$past(sync_pending), 7'h00};
  endproperty
  a_status: assert property (p_status) else $error("status read wrong");

  property p_clr_wrap;
    wr_clr && wdata_in[7] |=> !irq_enable[7];
  endproperty
  a_clr_wrap: assert property (p_clr_wrap) else $error("wrap enable not cleared");

  property p_pending;
    sync_busy_in ##1 sync_busy_in |-> sync_pending;
  endproperty
  a_pending: assert property (p_pending) else $error("busy not shown");

  property p_clr_sync;
    wr_clr && wdata_in[6] |=> !irq_enable[6];
  endproperty
  a_clr_sync: assert property (p_clr_sync) else $error("sync enable not cleared");

  property p_set_zero;
    wr_set |=> (irq_enable & ~$past(wdata_in)) == ($past(irq_enable) & ~$past(wdata_in));
  endproperty
  a_set_zero: assert property (p_set_zero) else $error("zero written to enable-set changed state");

  property p_clr_zero;
    wr_clr |=> (irq_enable & ~$past(wdata_in)) == ($past(irq_enable) & ~$past(wdata_in));
  endproperty
  a_clr_zero: assert property (p_clr_zero) else $error("zero written to enable-clear changed state");

  property p_flag_zero;
    wr_flag |=> ($past(irq_flags) & $past(valid_mask) & ~$past(wdata_in) & ~irq_flags) == 8'h00;
  endproperty
  a_flag_zero: assert property (p_flag_zero) else $error("zero written to a flag cleared it");

  property p_flag_one;
    wr_flag && event_set == 8'h00 |=> (irq_flags & $past(wdata_in)) == 8'h00;
  endproperty
  a_flag_one: assert property (p_flag_one) else $error("flag survived a one write");

  property p_chan_one;
    match_chan_n_in[1] && view == rtcirq_pkg::VIEW_COUNT16 |=> irq_flags[1];
  endproperty
  a_chan_one: assert property (p_chan_one) else $error("channel one flag not set");

  property p_chan_one_off;
    view != rtcirq_pkg::VIEW_COUNT16 |=> !irq_flags[1];
  endproperty
  a_chan_one_off: assert property (p_chan_one_off) else $error("channel one flag outside 16-bit view");

  property p_alarm_off;
    calendar_alarm_in && view != rtcirq_pkg::VIEW_CALENDAR && !match_chan_n_in[0] && !irq_flags[0] |=>
      !irq_flags[0];
  endproperty
  a_alarm_off: assert property (p_alarm_off) else $error("alarm flagged outside calendar view");

  property p_match_off;
    match_chan_n_in[0] && view == rtcirq_pkg::VIEW_CALENDAR && !calendar_alarm_in && !irq_flags[0] |=>
      !irq_flags[0];
  endproperty
  a_match_off: assert property (p_match_off) else $error("match flagged in calendar view");

  property p_wrap_cause;
    !counter_wrap_in && !irq_flags[7] |=> !irq_flags[7];
  endproperty
  a_wrap_cause: assert property (p_wrap_cause) else $error("wrap flag without wrap");

  property p_sync_cause;
    !busy_fall && !irq_flags[6] |=> !irq_flags[6];
  endproperty
  a_sync_cause: assert property (p_sync_cause) else $error("sync done without busy fall");

  property p_quiet_spell;
    s_quiet_spell ##0 !irq_flags[6] |=> !irq_flags[6];
  endproperty
  a_quiet_spell: assert property (p_quiet_spell) else $error("sync done after enable or soft reset");

  property p_loud_fall;
    s_loud_fall |=> irq_flags[6];
  endproperty
  a_loud_fall: assert property (p_loud_fall) else $error("sync done lost");

  property p_idle;
    !sync_busy_in |=> !sync_pending;
  endproperty
  a_idle: assert property (p_idle) else $error("busy shown while idle");

  property p_status_ro;
    wr_in && addr_in == rtcirq_pkg::OFS_STATUS |=> sync_pending == $past(sync_busy_in);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status changed by a write");

  property p_read_enable;
    rd_in && (addr_in == rtcirq_pkg::OFS_ENABLE_SET || addr_in == rtcirq_pkg::OFS_ENABLE_CLEAR) |=>
      rdata_out == $past(irq_enable);
  endproperty
  a_read_enable: assert property (p_read_enable) else $error("enable read wrong");

  property p_read_flags;
    rd_in && addr_in == rtcirq_pkg::OFS_FLAGS |=> rdata_out == $past(irq_flags);
  endproperty
  a_read_flags: assert property (p_read_flags) else $error("flag read wrong");

  property p_rdata_idle;
    !rd_in |=> rdata_out == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");

  property p_irq_wrap_off;
    irq_flags == 8'h80 && !irq_enable[7] |=> !irq_out;
  endproperty
  a_irq_wrap_off: assert property (p_irq_wrap_off) else $error("request from a disabled source");

  property p_flags_hold;
    !wr_flag && event_set == 8'h00 |=> irq_flags == ($past(irq_flags) & $past(valid_mask));
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flags changed without cause");

  property p_clr_chan_one;
    wr_clr && wdata_in[1] && view == rtcirq_pkg::VIEW_COUNT16 |=> !irq_enable[1];
  endproperty
  a_clr_chan_one: assert property (p_clr_chan_one) else $error("channel one enable not cleared");

  property p_cal_chan_one;
    wr_set && view == rtcirq_pkg::VIEW_CALENDAR |=> !irq_enable[1] || $past(irq_enable[1]);
  endproperty
  a_cal_chan_one: assert property (p_cal_chan_one) else $error("channel one enable in calendar view");

endmodule

// File: rtl/rtcirq_pkg.sv
// Constants of the counter interrupt flag block: offsets, bit positions, resets.
// Assumes an 8-bit register port and event pulses timed to mclk_in.
// Contract
// - Calendar view: writing one to enable-clear bit 0 drops the alarm enable.
// - Writing one to enable-set bit 7 turns the wrap enable on.
// - Writing one to enable-set bit 6 turns the sync-done enable on.
// - 32-bit view: enable-set bit 0 is the single match channel enable.
// - 16-bit view: enable-set bits 1 and 0 enable match channels one and zero.
// - Calendar view: enable-set bit 0 is the alarm enable.
// - Interrupt request is raised while any set flag has its enable on; irq_out is registered, so it rises and falls one cycle after the flags.
// - Writing one to a flag clears it; zero leaves it alone.
// - Wrap flag, bit 7, sets on the cycle after a counter wrap.
// - Counter views: each match flag sets on the cycle after its match.
// - Calendar view: alarm flag bit 0 sets on the cycle after an alarm match.
// - Sync-done flag sets when busy falls, unless enable or soft reset caused it.
// - Status bit 7 shows read-only sync busy, reset zero.
// - Enable-clear shares the set layout; one clears, zero does nothing.
// - Sync busy rises when a domain crossing starts, falls when it ends.
package rtcirq_pkg;

  localparam logic [7:0] OFS_ENABLE_CLEAR = 8'h06;
  localparam logic [7:0] OFS_ENABLE_SET   = 8'h07;
  localparam logic [7:0] OFS_FLAGS        = 8'h08;
  localparam logic [7:0] OFS_STATUS       = 8'h0A;
  localparam logic [7:0] OFS_VIEW         = 8'h20;

  localparam int BIT_WRAP      = 7;
  localparam int BIT_SYNC_DONE = 6;
  localparam int BIT_CHAN_ONE  = 1;
  localparam int BIT_CHAN_ZERO = 0;
  localparam int BIT_PENDING   = 7;

  localparam logic [7:0] RESET_ENABLE = 8'h00;
  localparam logic [7:0] RESET_FLAGS  = 8'h00;
  localparam logic [7:0] RESET_STATUS = 8'h00;

  localparam logic [7:0] MASK_COUNT32  = 8'hC1;
  localparam logic [7:0] MASK_COUNT16  = 8'hC3;
  localparam logic [7:0] MASK_CALENDAR = 8'hC1;

  localparam logic [1:0] VIEW_COUNT32  = 2'h0;
  localparam logic [1:0] VIEW_COUNT16  = 2'h1;
  localparam logic [1:0] VIEW_CALENDAR = 2'h2;
  localparam logic [1:0] RESET_VIEW    = 2'h0;

endpackage

// File: dv/rtcirq_cnt_model.sv
// Counter-side model: turns one-cycle requests into event pulses and busy spells.
// Assumes one request at a time from the bench, timed to mclk_in.
`timescale 1ns/1ns
module rtcirq_cnt_model (
  input  wire logic       mclk_in,
  input  wire logic [4:0] req_in,
  input  wire logic       cause_in,
  output logic            wrap_out,
  output logic      [1:0] match_out,
  output logic            alarm_out,
  output logic            busy_out,
  output logic            cause_out
);
  logic [1:0] left;
  logic       cause_r;
  initial {wrap_out, match_out, alarm_out, left, cause_r} = 7'h00;
  always @(posedge mclk_in) begin
    wrap_out  <= req_in[2];
    match_out <= req_in[1:0];
    alarm_out <= req_in[3];
    if (req_in[4]) begin
      left    <= 2'h3;
      cause_r <= cause_in;
    end else if (left != 2'h0) begin
      left <= left - 2'h1;
    end
  end
  // Three-cycle spell, long enough for the status copy to be read
  assign busy_out  = (left != 2'h0);
  // Cause only counts inside a spell, so it cannot leak into the next one
  assign cause_out = busy_out & cause_r;
endmodule

// File: dv/rtcirq_flags_tb.sv
// Self-checking bench of the interrupt flag block with a counter-side model.
// Assumes the register map and view masks of the package.
`timescale 1ns/1ns
module rtcirq_flags_tb;
  logic       mclk_in  = 1'b0;
  logic       reset_in = 1'b1;
  logic [7:0] addr_in  = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic       wr_in    = 1'b0;
  logic       rd_in    = 1'b0;
  logic       rd_d     = 1'b0;
  logic [4:0] req      = 5'h00;
  logic       cause    = 1'b0;
  logic [7:0] rdata_out;
  logic [1:0] match;
  logic       wrap;
  logic       alarm;
  logic       busy;
  logic       scause;
  logic       irq_out;
  logic [7:0] exp_q[$];
  logic [7:0] en;
  logic [7:0] fl;
  logic [7:0] msk;
  logic [7:0] r;
  integer     seed      = 35;
  int         err_total = 0;
  int         tests_run = 0;
  int         v;

  initial forever #5 mclk_in = ~mclk_in;

  rtcirq_cnt_model model (.mclk_in(mclk_in), .req_in(req), .cause_in(cause), .wrap_out(wrap),
    .match_out(match), .alarm_out(alarm), .busy_out(busy), .cause_out(scause));
  rtcirq_flags dut (.mclk_in(mclk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .counter_wrap_in(wrap), .match_chan_n_in(match),
    .calendar_alarm_in(alarm), .sync_busy_in(busy), .sync_cause_in(scause), .irq_out(irq_out));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_in);
    exp_q.push_back(e);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
  endtask
  task automatic fire(input logic [4:0] k, input logic c);
    @(posedge mclk_in);
    req   <= k;
    cause <= c;
    @(posedge mclk_in);
    req <= 5'h00;
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge mclk_in) begin
    if (rd_d) check(rdata_out, exp_q.pop_front());
    rd_d <= rd_in;
  end

  initial begin
    repeat (5000) @(posedge mclk_in);
    err_total++;
    give_verdict();
  end

  initial begin
    en = 8'h00;
    fl = 8'h00;
    repeat (5) @(posedge mclk_in);
    reset_in <= 1'b0;
    rd(rtcirq_pkg::OFS_ENABLE_SET, rtcirq_pkg::RESET_ENABLE);
    rd(rtcirq_pkg::OFS_FLAGS, rtcirq_pkg::RESET_FLAGS);
    rd(rtcirq_pkg::OFS_STATUS, rtcirq_pkg::RESET_STATUS);
    rd(8'h30, 8'h00);
    // View code 3 runs as the 32-bit view
    for (v = 0; v < 4; v++) begin
      msk = (v == 1) ? rtcirq_pkg::MASK_COUNT16 : (v == 2) ? rtcirq_pkg::MASK_CALENDAR : rtcirq_pkg::MASK_COUNT32;
      wr(rtcirq_pkg::OFS_VIEW, v[7:0]);
      r = 8'($random(seed));
      wr(rtcirq_pkg::OFS_ENABLE_SET, r);
      en = en | (r & msk);
      rd(rtcirq_pkg::OFS_ENABLE_SET, en);
      r = 8'($random(seed));
      wr(rtcirq_pkg::OFS_ENABLE_CLEAR, r);
      en = en & ~(r & msk);
      rd(rtcirq_pkg::OFS_ENABLE_CLEAR, en);
      // Wrap enable off, so its flag must not reach the request line
      wr(rtcirq_pkg::OFS_ENABLE_SET, 8'hFF);
      wr(rtcirq_pkg::OFS_ENABLE_CLEAR, 8'h80);
      en = msk & 8'h7F;
      fire(5'h04, 1'b0);
      fl = 8'h80;
      rd(rtcirq_pkg::OFS_FLAGS, fl);
      #1 check({7'h00, irq_out}, 8'h00);
      fire(5'h03, 1'b0);
      fl = fl | ((v == 2) ? 8'h00 : (v == 1) ? 8'h03 : 8'h01);
      fire(5'h08, 1'b0);
      fl = fl | ((v == 2) ? 8'h01 : 8'h00);
      rd(rtcirq_pkg::OFS_FLAGS, fl);
      #1 check({7'h00, irq_out}, {7'h00, (fl & en) != 8'h00});
      r = 8'($random(seed));
      wr(rtcirq_pkg::OFS_FLAGS, r);
      fl = fl & ~r;
      rd(rtcirq_pkg::OFS_FLAGS, fl);
      wr(rtcirq_pkg::OFS_FLAGS, 8'hFF);
      wr(rtcirq_pkg::OFS_ENABLE_CLEAR, 8'hFF);
      fl = 8'h00;
      en = 8'h00;
    end
    wr(rtcirq_pkg::OFS_ENABLE_SET, 8'h40);
    fire(5'h10, 1'b0);
    rd(rtcirq_pkg::OFS_STATUS, 8'h80);
    repeat (4) @(posedge mclk_in);
    rd(rtcirq_pkg::OFS_FLAGS, 8'h40);
    #1 check({7'h00, irq_out}, 8'h01);
    wr(rtcirq_pkg::OFS_FLAGS, 8'h40);
    fire(5'h10, 1'b1);
    repeat (6) @(posedge mclk_in);
    rd(rtcirq_pkg::OFS_FLAGS, 8'h00);
    wr(rtcirq_pkg::OFS_STATUS, 8'hFF);
    rd(rtcirq_pkg::OFS_STATUS, 8'h00);
    #1 check({7'h00, irq_out}, 8'h00);
    give_verdict();
  end
endmodule
